// >>> rtl/qpd_top.sv
`timescale 1ns/10ps
`default_nettype none
module qpd_top
    import qpd_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYC
)(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_sck,
    input  wire logic        i_cs_b,
    input  wire logic        i_si,
    input  wire logic [1:0]  i_strap_address,
    output logic             o_so,
    output logic             o_so_oe_b,
    output logic [63:0]      o_tap_ch0,
    output logic [63:0]      o_tap_ch1,
    output logic [63:0]      o_tap_ch2,
    output logic [63:0]      o_tap_ch3,
    output logic             o_nv_write_pending
);
    import qpd_pkg::*;

    typedef enum logic [2:0] {
        ST_LOAD = 3'b001,
        ST_IDLE = 3'b010,
        ST_BUSY = 3'b100
    } qpd_st_t;

    typedef struct packed {
        qpd_st_t     st;
        logic [NUM_CH-1:0][5:0]                 wiper_position_reg;
        logic [NUM_CH-1:0][NUM_PRESET-1:0][5:0] preset_store_reg;
        logic        nv_known;
        logic [31:0] wcnt;
        logic [2:0]  frm_sync;
        logic [2:0]  stp_sync;
        logic [1:0]  up_sync;
        logic [1:0]  cs_sync;
        logic        cs_d;
        logic        wr_armed;
        logic [15:0] cmd;
        logic [7:0]  data;
        logic [5:0]  rd_data;
    } qpd_core_t;

    qpd_core_t s;
    qpd_core_t next_s;

    logic [15:0] l_cmd;
    logic [7:0]  l_data;
    logic        l_frame_tgl;
    logic        l_step_tgl;
    logic        l_step_up;
    logic        l_full;
    logic        frame_ev;
    logic        step_ev;
    logic        cs_rise;
    logic [3:0]  op;
    logic [1:0]  psel;
    logic [1:0]  chsel;
    logic        busy;

    // ****************************************
    // link side
    // ****************************************
    qpd_link u_link (
        .i_sck       (i_sck),
        .i_cs_b      (i_cs_b),
        .i_si        (i_si),
        .i_strap     (i_strap_address),
        .i_rd_data   (s.rd_data),
        .o_so        (o_so),
        .o_so_oe_b   (o_so_oe_b),
        .o_cmd       (l_cmd),
        .o_data      (l_data),
        .o_frame_tgl (l_frame_tgl),
        .o_step_tgl  (l_step_tgl),
        .o_step_up   (l_step_up),
        .o_full      (l_full)
    );

    // ****************************************
    // core state
    // ****************************************
    assign frame_ev = s.frm_sync[1] & ~s.frm_sync[2];
    // the link clears its step toggle at frame end; mask that edge
    assign step_ev  = (s.stp_sync[2] ^ s.stp_sync[1]) & ~s.cs_sync[1];
    assign cs_rise  = s.cs_sync[1] & ~s.cs_d;
    assign op       = s.cmd[7:4];
    assign psel     = s.cmd[3:2];
    assign chsel    = s.cmd[1:0];
    assign busy     = (s.st == ST_BUSY);

    always_comb begin
        next_s = s;
        next_s.frm_sync = {s.frm_sync[1:0], l_frame_tgl};
        next_s.stp_sync = {s.stp_sync[1:0], l_step_tgl};
        next_s.up_sync  = {s.up_sync[0], l_step_up};
        next_s.cs_sync  = {s.cs_sync[0], i_cs_b};
        next_s.cs_d     = s.cs_sync[1];
        unique case (s.st)
            ST_LOAD: begin
                for (int c = 0; c < NUM_CH; c++) begin
                    next_s.wiper_position_reg[c] = s.preset_store_reg[c][0];
                end
                next_s.st = ST_IDLE;
            end
            ST_IDLE: begin
                if (cs_rise && s.wr_armed) begin
                    next_s.wr_armed = 1'b0;
                    next_s.nv_known = 1'b1;
                    next_s.wcnt     = 32'd0;
                    next_s.st       = ST_BUSY;
                    unique case (op)
                        OP_WR_PRESET: next_s.preset_store_reg[chsel][psel] = s.data[5:0];
                        OP_XFR_W2P: begin
                            next_s.preset_store_reg[chsel][psel] = s.wiper_position_reg[chsel];
                        end
                        default: begin
                            for (int c = 0; c < NUM_CH; c++) begin
                                next_s.preset_store_reg[c][psel] = s.wiper_position_reg[c];
                            end
                        end
                    endcase
                end
            end
            ST_BUSY: begin
                next_s.wcnt = s.wcnt + 32'd1;
                if (s.wcnt >= 32'(WRITE_CYCLES - 1)) begin
                    next_s.st = ST_IDLE;
                end
            end
            default: next_s.st = ST_IDLE;
        endcase
        if (frame_ev) begin
            next_s.cmd  = l_cmd;
            next_s.data = l_data;
            unique case (l_cmd[7:4])
                OP_RD_WIPER:  next_s.rd_data = s.wiper_position_reg[l_cmd[1:0]];
                OP_RD_PRESET: next_s.rd_data = s.preset_store_reg[l_cmd[1:0]][l_cmd[3:2]];
                OP_STATUS:    next_s.rd_data = {5'b00000, busy};
                OP_WR_WIPER: begin
                    if (l_full) next_s.wiper_position_reg[l_cmd[1:0]] = l_data[5:0];
                end
                OP_XFR_P2W: begin
                    next_s.wiper_position_reg[l_cmd[1:0]] = s.preset_store_reg[l_cmd[1:0]][l_cmd[3:2]];
                end
                OP_GXFR_P2W: begin
                    for (int c = 0; c < NUM_CH; c++) begin
                        next_s.wiper_position_reg[c] = s.preset_store_reg[c][l_cmd[3:2]];
                    end
                end
                OP_WR_PRESET, OP_XFR_W2P, OP_GXFR_W2P: begin
                    if (!busy) next_s.wr_armed = 1'b1;
                end
                default: next_s.rd_data = s.rd_data;
            endcase
        end
        if (step_ev && s.cmd[7:4] == OP_STEP && s.st != ST_LOAD) begin
            if (s.up_sync[1] && s.wiper_position_reg[chsel] != 6'h3F) begin
                next_s.wiper_position_reg[chsel] = s.wiper_position_reg[chsel] + 6'h01;
            end else if (!s.up_sync[1] && s.wiper_position_reg[chsel] != 6'h00) begin
                next_s.wiper_position_reg[chsel] = s.wiper_position_reg[chsel] - 6'h01;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s.st       <= ST_LOAD;
            s.wcnt     <= 32'd0;
            s.frm_sync <= 3'b000;
            s.stp_sync <= 3'b000;
            s.up_sync  <= 2'b00;
            s.cs_sync  <= 2'b11;
            s.cs_d     <= 1'b1;
            s.wr_armed <= 1'b0;
            s.cmd      <= 16'h0000;
            s.data     <= 8'h00;
            s.rd_data  <= 6'h00;
            for (int c = 0; c < NUM_CH; c++) begin
                s.wiper_position_reg[c] <= 6'h00;
            end
        end else begin
            s.st                 <= next_s.st;
            s.wcnt               <= next_s.wcnt;
            s.frm_sync           <= next_s.frm_sync;
            s.stp_sync           <= next_s.stp_sync;
            s.up_sync            <= next_s.up_sync;
            s.cs_sync            <= next_s.cs_sync;
            s.cs_d               <= next_s.cs_d;
            s.wr_armed           <= next_s.wr_armed;
            s.cmd                <= next_s.cmd;
            s.data               <= next_s.data;
            s.rd_data            <= next_s.rd_data;
            s.wiper_position_reg <= next_s.wiper_position_reg;
            // nonvolatile store survives reset, so the reset branch leaves it
            s.preset_store_reg   <= next_s.preset_store_reg;
            s.nv_known           <= next_s.nv_known;
        end
    end

    // ****************************************
    // tap decode
    // ****************************************
    assign o_tap_ch0          = 64'h1 << s.wiper_position_reg[0];
    assign o_tap_ch1          = 64'h1 << s.wiper_position_reg[1];
    assign o_tap_ch2          = 64'h1 << s.wiper_position_reg[2];
    assign o_tap_ch3          = 64'h1 << s.wiper_position_reg[3];
    assign o_nv_write_pending = busy;

    // ****************************************
    // checks
    // ****************************************
    a_load_after_reset: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        s.nv_known && s.st == ST_LOAD
        |=> s.wiper_position_reg[0] == $past(s.preset_store_reg[0][0]))
        else $error("wiper not loaded from preset zero");
    a_busy_status: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        frame_ev && l_cmd[7:4] == OP_STATUS |=> s.rd_data[0] == $past(busy))
        else $error("status bit wrong");
    a_store_starts: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        s.st == ST_IDLE && cs_rise && s.wr_armed |=> busy)
        else $error("store did not start");
    a_busy_ends: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        busy && s.wcnt == 32'(WRITE_CYCLES - 1) |=> !busy)
        else $error("write cycle too long");
    a_no_arm_busy: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        busy && !$past(busy) |-> !s.wr_armed)
        else $error("write armed while busy");
    a_tap_onehot: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        frame_ev && l_full && l_cmd[7:4] == OP_WR_WIPER && l_cmd[1:0] == 2'h2
        |=> $onehot(o_tap_ch2))
        else $error("tap not one-hot");
    a_wiper_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        frame_ev && l_full && l_cmd[7:4] == OP_WR_WIPER && s.st != ST_LOAD
        |=> s.wiper_position_reg[$past(l_cmd[1:0])] == $past(l_data[5:0]))
        else $error("wiper write lost");
    a_step_bound: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        step_ev && s.cmd[7:4] == OP_STEP && s.up_sync[1] && s.wiper_position_reg[chsel] == 6'h3F
        |=> s.wiper_position_reg[$past(chsel)] == 6'h3F)
        else $error("step wrapped");
    c_store: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) busy && !$past(busy));
    c_step: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) step_ev);
    c_read: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) frame_ev && l_cmd[7:4] == OP_RD_PRESET);
endmodule
`default_nettype wire

// >>> shared/qpd_pkg.sv
package qpd_pkg;
    localparam int         NUM_CH       = 4;
    localparam int         NUM_PRESET   = 4;
    localparam int         WIPER_W      = 6;
    localparam logic [3:0] TYPE_ID      = 4'h5;
    localparam logic [3:0] OP_RD_WIPER  = 4'h9;
    localparam logic [3:0] OP_WR_WIPER  = 4'hA;
    localparam logic [3:0] OP_RD_PRESET = 4'hB;
    localparam logic [3:0] OP_WR_PRESET = 4'hC;
    localparam logic [3:0] OP_XFR_P2W   = 4'hD;
    localparam logic [3:0] OP_XFR_W2P   = 4'hE;
    localparam logic [3:0] OP_GXFR_P2W  = 4'h1;
    localparam logic [3:0] OP_GXFR_W2P  = 4'h8;
    localparam logic [3:0] OP_STEP      = 4'h2;
    localparam logic [3:0] OP_STATUS    = 4'h5;
    localparam int         CLK_MHZ      = 40;
    localparam int         T_WRITE_US   = 5000;
    localparam int         WRITE_CYC    = T_WRITE_US * CLK_MHZ;
    localparam logic [5:0] PRESET_RST   = 6'h00;
endpackage

// >>> rtl/qpd_link.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// link side shifter on serial clock
// ****************************************
module qpd_link
    import qpd_pkg::*;
(
    input  wire logic       i_sck,
    input  wire logic       i_cs_b,
    input  wire logic       i_si,
    input  wire logic [1:0] i_strap,
    input  wire logic [5:0] i_rd_data,
    output logic            o_so,
    output logic            o_so_oe_b,
    output logic [15:0]     o_cmd,
    output logic [7:0]      o_data,
    output logic            o_frame_tgl,
    output logic            o_step_tgl,
    output logic            o_step_up,
    output logic            o_full
);
    typedef struct packed {
        logic [4:0]  cnt;
        logic [15:0] cmd;
        logic [7:0]  data;
        logic        mismatch;
        logic        full;
        logic        done;
        logic        step_tgl;
        logic        step_up;
    } qpd_lnk_t;
    qpd_lnk_t   s;
    qpd_lnk_t   next_s;
    logic [7:0] sh_out;
    logic       so_q;
    logic [3:0] early_op;
    logic       three_byte;

    // opcode as it stands once fifteen bits are in
    assign early_op   = s.cmd[6:3];
    assign three_byte = (early_op == OP_RD_WIPER) || (early_op == OP_WR_WIPER) ||
                        (early_op == OP_RD_PRESET) || (early_op == OP_WR_PRESET) ||
                        (early_op == OP_STATUS);

    // done is a level held until chip select rises, so the core sees stable fields
    always_comb begin
        next_s = s;
        if (!s.mismatch) begin
            if (s.cnt < 5'd16) begin
                next_s.cmd = {s.cmd[14:0], i_si};
                next_s.cnt = s.cnt + 5'd1;
                if (s.cnt == 5'd7 && s.cmd[6:3] != TYPE_ID) begin
                    next_s.mismatch = 1'b1;
                end
                if (s.cnt == 5'd7 && {s.cmd[0], i_si} != i_strap) begin
                    next_s.mismatch = 1'b1;
                end
                if (s.cnt == 5'd15 && !three_byte) begin
                    next_s.done = 1'b1;
                end
            end else if (s.cmd[7:4] == OP_STEP) begin
                next_s.step_tgl = ~s.step_tgl;
                next_s.step_up  = i_si;
            end else if (s.cnt < 5'd24) begin
                next_s.data = {s.data[6:0], i_si};
                next_s.cnt  = s.cnt + 5'd1;
                if (s.cnt == 5'd23) begin
                    next_s.full = 1'b1;
                    next_s.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_sck or posedge i_cs_b) begin
        if (i_cs_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // read data shifted out on falling edge, msb first
    assign sh_out = {2'b00, i_rd_data};
    always_ff @(negedge i_sck or posedge i_cs_b) begin
        if (i_cs_b) begin
            so_q <= 1'b0;
        end else begin
            so_q <= (s.cnt >= 5'd16 && s.cnt < 5'd24) ? sh_out[3'd7 - s.cnt[2:0]] : 1'b0;
        end
    end

    assign o_so        = so_q;
    assign o_so_oe_b   = i_cs_b | s.mismatch | (s.cnt < 5'd16);
    assign o_cmd       = s.cmd;
    assign o_data      = s.data;
    assign o_frame_tgl = s.done;
    assign o_step_tgl  = s.step_tgl;
    assign o_step_up   = s.step_up;
    assign o_full      = s.full;
endmodule
`default_nettype wire

// >>> bench/qpd_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// serial master model, link clock idles low outside frames
// ****************************************
module qpd_host #(
    parameter real HALF_NS = 62.5
)(
    output logic      o_sck,
    output logic      o_cs_b,
    output logic      o_si,
    input  wire logic i_so,
    input  wire logic i_so_oe_b
);
    initial begin
        o_sck  = 1'b0;
        o_cs_b = 1'b0;
        o_si   = 1'b0;
        // a clean rising edge clears the link state
        #1;
        o_cs_b = 1'b1;
    end

    task automatic frame(input logic [1:0] adr, input logic [3:0] tid, input logic [55:0] rest, input int n,
                         output logic [7:0] rd, output logic drv);
        logic [63:0] bits;
        bits   = {tid, 2'h0, adr, rest};
        rd     = 8'h00;
        drv    = 1'b1;
        #3.3;
        o_cs_b = 1'b0;
        #250;
        for (int i = 0; i < n; i++) begin
            o_si = bits[63 - i];
            #HALF_NS;
            o_sck = 1'b1;
            if (i >= 16 && i < 24) begin
                rd  = {rd[6:0], i_so};
                drv = drv & (i_so_oe_b === 1'b0);
            end
            #HALF_NS;
            o_sck = 1'b0;
        end
        #250;
        o_cs_b = 1'b1;
        o_si   = ~o_si;
        #250;
    endtask
endmodule
`default_nettype wire

// >>> bench/quad_pot_serial_command_decoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
module quad_pot_serial_command_decoder_bench;
    import qpd_pkg::*;
    localparam int         WR_CYC = 800;
    localparam logic [1:0] STRAP  = 2'h2;
    typedef struct packed {
        logic [3:0]  op;
        logic [1:0]  sel;
        logic [1:0]  ch;
        logic [7:0]  dat;
        logic        lng;
        logic        store;
        logic        chk;
        logic [23:0] exp_w;
    } qpd_row_t;
    logic        clk;
    logic        rst_b;
    logic        sck;
    logic        cs_b;
    logic        si;
    logic        so;
    logic        so_oe_b;
    logic        pend;
    logic [63:0] tap [4];
    logic [7:0]  rd;
    logic        drv;
    int          err_total;
    int          total_checks;
    qpd_row_t    rows [18];

    qpd_top #(.WRITE_CYCLES(WR_CYC)) i_dut (
        .i_core_clk        (clk),     .i_rst_b         (rst_b),
        .i_sck             (sck),     .i_cs_b          (cs_b),
        .i_si              (si),      .i_strap_address (STRAP),
        .o_so              (so),      .o_so_oe_b       (so_oe_b),
        .o_tap_ch0         (tap[0]),  .o_tap_ch1       (tap[1]),
        .o_tap_ch2         (tap[2]),  .o_tap_ch3       (tap[3]),
        .o_nv_write_pending(pend)
    );
    qpd_host i_host (.o_sck(sck), .o_cs_b(cs_b), .o_si(si), .i_so(so), .i_so_oe_b(so_oe_b));

    always #12.5 clk = ~clk;

    // ****************************************
    // compare and frame tasks
    // ****************************************
    task automatic chk_tap(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t tap got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t byte got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t flag got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_taps(input logic [23:0] w);
        for (int c = 0; c < 4; c++) begin
            chk_tap(tap[c], 64'h1 << w[c*6 +: 6]);
        end
    endtask
    task automatic send(input logic [1:0] adr, input logic [3:0] tid, input logic [15:0] body, input int n);
        i_host.frame(adr, tid, {body, 40'h0}, n, rd, drv);
        repeat (8) @(negedge clk);
    endtask
    task automatic wait_store();
        int n;
        n = 0;
        chk_flag(pend, 1'b1);
        while (pend === 1'b1 && n < WR_CYC + 50) begin
            @(negedge clk);
            n++;
        end
        chk_flag(pend, 1'b0);
        chk_flag(n <= WR_CYC, 1'b1);
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        err_total++;
        $display("BAD t=%0t watchdog expired got=%h exp=%h", $time, 1'b1, 1'b0);
        give_verdict();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        err_total = 0;
        total_checks = 0;
        rows = '{
            '{OP_WR_PRESET, 2'h0, 2'h0, 8'h11, 1'b1, 1'b1, 1'b0, 24'h0},
            '{OP_WR_PRESET, 2'h0, 2'h1, 8'h22, 1'b1, 1'b1, 1'b0, 24'h0},
            '{OP_WR_PRESET, 2'h0, 2'h2, 8'h33, 1'b1, 1'b1, 1'b0, 24'h0},
            '{OP_WR_PRESET, 2'h0, 2'h3, 8'h0C, 1'b1, 1'b1, 1'b0, 24'h0},
            '{OP_GXFR_P2W, 2'h0, 2'h0, 8'h00, 1'b0, 1'b0, 1'b1, {6'h0C, 6'h33, 6'h22, 6'h11}},
            '{OP_WR_WIPER, 2'h0, 2'h0, 8'h05, 1'b1, 1'b0, 1'b1, {6'h0C, 6'h33, 6'h22, 6'h05}},
            '{OP_WR_WIPER, 2'h0, 2'h1, 8'h3F, 1'b1, 1'b0, 1'b1, {6'h0C, 6'h33, 6'h3F, 6'h05}},
            '{OP_WR_WIPER, 2'h0, 2'h2, 8'h00, 1'b1, 1'b0, 1'b1, {6'h0C, 6'h00, 6'h3F, 6'h05}},
            '{OP_WR_WIPER, 2'h0, 2'h3, 8'h2A, 1'b1, 1'b0, 1'b1, {6'h2A, 6'h00, 6'h3F, 6'h05}},
            '{OP_WR_PRESET, 2'h3, 2'h0, 8'h3E, 1'b1, 1'b1, 1'b1, {6'h2A, 6'h00, 6'h3F, 6'h05}},
            '{OP_XFR_P2W, 2'h3, 2'h0, 8'h00, 1'b0, 1'b0, 1'b1, {6'h2A, 6'h00, 6'h3F, 6'h3E}},
            '{OP_XFR_W2P, 2'h2, 2'h1, 8'h00, 1'b0, 1'b1, 1'b1, {6'h2A, 6'h00, 6'h3F, 6'h3E}},
            '{OP_GXFR_W2P, 2'h1, 2'h0, 8'h00, 1'b0, 1'b1, 1'b1, {6'h2A, 6'h00, 6'h3F, 6'h3E}},
            '{OP_WR_WIPER, 2'h0, 2'h3, 8'h01, 1'b1, 1'b0, 1'b1, {6'h01, 6'h00, 6'h3F, 6'h3E}},
            '{OP_WR_WIPER, 2'h0, 2'h1, 8'h10, 1'b1, 1'b0, 1'b1, {6'h01, 6'h00, 6'h10, 6'h3E}},
            '{OP_XFR_P2W, 2'h2, 2'h1, 8'h00, 1'b0, 1'b0, 1'b1, {6'h01, 6'h00, 6'h3F, 6'h3E}},
            '{OP_GXFR_P2W, 2'h1, 2'h0, 8'h00, 1'b0, 1'b0, 1'b1, {6'h2A, 6'h00, 6'h3F, 6'h3E}},
            '{OP_XFR_P2W, 2'h0, 2'h2, 8'h00, 1'b0, 1'b0, 1'b1, {6'h2A, 6'h33, 6'h3F, 6'h3E}}
        };
        repeat (4) @(negedge clk);
        chk_flag(pend, 1'b0);
        chk_flag(so_oe_b, 1'b1);
        rst_b = 1'b1;
        #1_000_000;
        foreach (rows[k]) begin
            send(STRAP, TYPE_ID, {rows[k].op, rows[k].sel, rows[k].ch, rows[k].dat}, rows[k].lng ? 24 : 16);
            if (rows[k].store) begin
                wait_store();
            end
            if (rows[k].chk) begin
                check_taps(rows[k].exp_w);
            end
        end
        $display("test table done");
        for (int k = 0; k < 2; k++) begin
            send(STRAP, TYPE_ID, {OP_RD_WIPER, 4'h1, 8'h00}, 24);
        end
        chk_byte(rd, 8'h3F);
        chk_flag(drv, 1'b1);
        for (int k = 0; k < 2; k++) begin
            send(STRAP, TYPE_ID, {OP_RD_PRESET, 4'hC, 8'h00}, 24);
        end
        chk_byte(rd, 8'h3E);
        $display("test reads done");
        send(STRAP, TYPE_ID, {OP_WR_PRESET, 4'h6, 8'h15}, 24);
        send(STRAP, TYPE_ID, {OP_WR_PRESET, 4'h6, 8'h2B}, 24);
        send(STRAP, TYPE_ID, {OP_STATUS, 4'h1, 8'h00}, 24);
        send(STRAP, TYPE_ID, {OP_STATUS, 4'h1, 8'h00}, 24);
        chk_byte(rd, 8'h01);
        wait_store();
        send(STRAP, TYPE_ID, {OP_STATUS, 4'h1, 8'h00}, 24);
        send(STRAP, TYPE_ID, {OP_STATUS, 4'h1, 8'h00}, 24);
        chk_byte(rd, 8'h00);
        send(STRAP, TYPE_ID, {OP_RD_PRESET, 4'h6, 8'h00}, 24);
        send(STRAP, TYPE_ID, {OP_RD_PRESET, 4'h6, 8'h00}, 24);
        chk_byte(rd, 8'h15);
        $display("test busy store done");
        send(STRAP ^ 2'h1, TYPE_ID, {OP_WR_WIPER, 4'h0, 8'h07}, 24);
        send(STRAP, 4'hA, {OP_WR_WIPER, 4'h0, 8'h07}, 24);
        send(STRAP ^ 2'h3, TYPE_ID, {OP_RD_WIPER, 4'h0, 8'h00}, 24);
        chk_flag(drv, 1'b0);
        chk_flag(pend, 1'b0);
        check_taps({6'h2A, 6'h33, 6'h3F, 6'h3E});
        $display("test address mismatch done");
        send(STRAP, TYPE_ID, {OP_STEP, 4'h1, 8'hC0}, 21);
        check_taps({6'h2A, 6'h33, 6'h3C, 6'h3E});
        $display("test step done");
        rst_b = 1'b0;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        check_taps({6'h0C, 6'h33, 6'h22, 6'h11});
        chk_flag(so_oe_b, 1'b1);
        $display("test power cycle done");
        give_verdict();
    end
endmodule
`default_nettype wire
